/* File: hdl/stu_timing_unit.sv */
// station timing unit: mark recovery, frame ticks, reference, gate qualify
`timescale 1ns/1ps
module stu_timing_unit
  import stu_pkg::*;
#(
  parameter int unsigned HALF_CYC = TICK_HALF_CYC,
  parameter int unsigned GAP_CYC  = MARK_GAP_CYC
) (
  // clock and reset
  input  wire logic            core_clk_i,
  input  wire logic            rst_i,
  // site reference and loop status
  input  wire logic            site_ref_i,
  input  wire logic            ref_stable_i,
  input  wire logic            loop_align_i,
  // receive processor control port
  input  wire stu_dsp_req_type dsp_req_i,
  output logic [DATA_W-1:0]    dsp_rdata_o,
  // timing outputs to processors
  output stu_timing_type       tx_timing_o,
  output stu_timing_type       rx0_timing_o,
  output stu_timing_type       rx1_timing_o,
  // exciter reference and loop gate
  output logic                 txref_o,
  output logic                 gate_en_o
);
  localparam int CW = $clog2(HALF_CYC + 1);

  // control registers
  logic [7:0]     ctrl_q;
  logic [7:0]     ctrl_d;
  logic [7:0]     winlen_q;
  logic [7:0]     winlen_d;
  logic [7:0]     rdata_q;
  logic [7:0]     rdata_d;
  logic           run;
  // mark recovery
  logic           ref_d1_q;
  logic           ref_d1_d;
  logic [7:0]     quiet_q;
  logic [7:0]     quiet_d;
  logic           mark_q;
  logic           mark_d;
  logic           seen_q;
  logic           seen_d;
  // ticks and window
  logic [CW-1:0]  half_q;
  logic [CW-1:0]  half_d;
  logic           phase_q;
  logic           phase_d;
  logic           t15_q;
  logic           t15_d;
  logic           t75_q;
  logic           t75_d;
  logic [7:0]     win_q;
  logic [7:0]     win_d;
  logic           winout_q;
  logic           winout_d;
  // gate qualify
  logic [1:0]     align_q;
  logic [1:0]     align_d;
  logic           al_d1_q;
  logic           al_d1_d;
  logic           gate_q;
  logic           gate_d;
  stu_timing_type tim;

  // one decode for every register write strobe
  function automatic logic wr_hit(
    input stu_dsp_req_type   req,
    input logic [ADDR_W-1:0] addr
  );
    return req.cs && req.wr && (req.addr == addr);
  endfunction

  always_comb begin
    run = ctrl_q[CTRL_RUN_BIT];
    ctrl_d   = ctrl_q;
    winlen_d = winlen_q;
    rdata_d  = rdata_q;
    if (wr_hit(dsp_req_i, ADDR_CTRL)) begin
      ctrl_d = dsp_req_i.wdata;
    end
    if (wr_hit(dsp_req_i, ADDR_WINLEN)) begin
      winlen_d = dsp_req_i.wdata;
    end
    if (dsp_req_i.cs && dsp_req_i.rd) begin
      case (dsp_req_i.addr)
        ADDR_CTRL:   rdata_d = ctrl_q;
        ADDR_STATUS: rdata_d = {3'h0, gate_q, align_q, seen_q, phase_q};
        ADDR_WINLEN: rdata_d = winlen_q;
        default:     rdata_d = 8'h00;
      endcase
    end
  end

  // mark is a gap in the 5 MHz carrier; a rising edge after a quiet run ends it
  always_comb begin
    ref_d1_d = site_ref_i;
    quiet_d  = quiet_q;
    mark_d   = 1'b0;
    seen_d   = seen_q;
    if (site_ref_i != ref_d1_q) begin
      quiet_d = 8'h00;
      if (site_ref_i && quiet_q >= 8'(GAP_CYC)) begin
        mark_d = run;
        seen_d = seen_q | run;
      end
    end else if (quiet_q != 8'hff) begin
      quiet_d = quiet_q + 8'h01;
    end
  end

  always_comb begin
    half_d  = half_q;
    phase_d = phase_q;
    t15_d   = 1'b0;
    t75_d   = 1'b0;
    if (mark_d) begin
      half_d  = '0;
      phase_d = 1'b0;
      t15_d   = 1'b1;
      t75_d   = 1'b1;
    end else if (seen_q) begin
      if (half_q == CW'(HALF_CYC - 1)) begin
        half_d  = '0;
        phase_d = ~phase_q;
        t75_d   = 1'b1;
        t15_d   = phase_q;
      end else begin
        half_d = half_q + CW'(1);
      end
    end
    win_d    = mark_d ? winlen_q : (win_q != 8'h00 ? win_q - 8'h01 : 8'h00);
    winout_d = mark_d || (win_q > 8'h01);
  end

  // count rising edges of the alignment indication; two needed before closing
  always_comb begin
    al_d1_d = loop_align_i;
    align_d = align_q;
    if (!ref_stable_i || !ctrl_q[CTRL_PROG_BIT]) begin
      align_d = 2'h0;
    end else if (loop_align_i && !al_d1_q && align_q != 2'(ALIGN_NEEDED)) begin
      align_d = align_q + 2'h1;
    end
    gate_d = ref_stable_i && ctrl_q[CTRL_PROG_BIT]
             && (align_q == 2'(ALIGN_NEEDED));
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_q   <= CTRL_RESET;
      winlen_q <= WINLEN_RESET;
      rdata_q  <= 8'h00;
    end else begin
      ctrl_q   <= ctrl_d;
      winlen_q <= winlen_d;
      rdata_q  <= rdata_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ref_d1_q <= 1'b0;
      quiet_q  <= 8'h00;
      mark_q   <= 1'b0;
      seen_q   <= 1'b0;
    end else begin
      ref_d1_q <= ref_d1_d;
      quiet_q  <= quiet_d;
      mark_q   <= mark_d;
      seen_q   <= seen_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      half_q   <= '0;
      phase_q  <= 1'b0;
      t15_q    <= 1'b0;
      t75_q    <= 1'b0;
      win_q    <= 8'h00;
      winout_q <= 1'b0;
    end else begin
      half_q   <= half_d;
      phase_q  <= phase_d;
      t15_q    <= t15_d;
      t75_q    <= t75_d;
      win_q    <= win_d;
      winout_q <= winout_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      align_q  <= 2'h0;
      al_d1_q  <= 1'b0;
      gate_q   <= 1'b0;
    end else begin
      align_q  <= align_d;
      al_d1_q  <= al_d1_d;
      gate_q   <= gate_d;
    end
  end

  assign tim = '{mark: mark_q, mark_window: winout_q, tick_15ms: t15_q, tick_7p5ms: t75_q};
  // same flops fan out to all three processors so they stay in step
  assign tx_timing_o  = tim;
  assign rx0_timing_o = tim;
  assign rx1_timing_o = tim;
  assign dsp_rdata_o  = rdata_q;
  assign gate_en_o    = gate_q;

  stu_div7 #(
    .DIV (TXREF_DIV)
  ) u_div7 (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .txref_o    (txref_o)
  );
endmodule

/* File: hdl/stu_pkg.sv */
// package of constants and carrier types for the station timing unit
package stu_pkg;
  localparam int unsigned CLK_HZ          = 16800000;
  localparam int unsigned TXREF_DIV       = 7;
  localparam int unsigned TXREF_HIGH      = 4;
  localparam int unsigned TICK_HALF_US    = 7500;
  localparam int unsigned TICK_HALF_CYC   = CLK_HZ / 1000 * TICK_HALF_US / 1000;
  localparam int unsigned MARK_GAP_CYC    = 8;
  localparam int unsigned WINDOW_CYC      = 64;
  localparam int unsigned ALIGN_NEEDED    = 2;
  localparam int unsigned ADDR_W          = 4;
  localparam int unsigned DATA_W          = 8;
  localparam logic [3:0]  ADDR_CTRL       = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h1;
  localparam logic [3:0]  ADDR_WINLEN     = 4'h2;
  localparam int unsigned CTRL_RUN_BIT    = 0;
  localparam int unsigned CTRL_PROG_BIT   = 1;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  WINLEN_RESET    = 8'h40;

  typedef struct packed {
    logic mark;
    logic mark_window;
    logic tick_15ms;
    logic tick_7p5ms;
  } stu_timing_type;

  typedef struct packed {
    logic              cs;
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } stu_dsp_req_type;
endpackage

/* File: hdl/stu_div7.sv */
// free-running divide-by-seven transmitter reference
`timescale 1ns/1ps
module stu_div7
  import stu_pkg::*;
#(
  parameter int unsigned DIV = TXREF_DIV
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // reference out
  output logic      txref_o
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic       ref_q;
  logic       ref_d;

  always_comb begin
    cnt_d = (cnt_q == 3'(DIV - 1)) ? 3'h0 : cnt_q + 3'h1;
    ref_d = (cnt_d < 3'(TXREF_HIGH));
  end

  // no gating by mark state, so the exciter reference never drops out
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      // start one short of wrap so the first high phase is full length
      cnt_q <= 3'(DIV - 1);
      ref_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ref_q <= ref_d;
    end
  end

  assign txref_o = ref_q;
endmodule

/* File: tb/stu_props.sv */
// checker for the station timing unit ports
`timescale 1ns/1ps
module stu_props
  import stu_pkg::*;
#(
  parameter int unsigned HALF_CYC = 20
) (
  // watched ports
  input wire logic              core_clk_i,
  input wire logic              rst_i,
  input wire logic              site_ref_i,
  input wire logic              ref_stable_i,
  input wire logic              loop_align_i,
  input wire stu_dsp_req_type   dsp_req_i,
  input wire logic [DATA_W-1:0] dsp_rdata_o,
  input wire stu_timing_type    tx_timing_o,
  input wire stu_timing_type    rx0_timing_o,
  input wire stu_timing_type    rx1_timing_o,
  input wire logic              txref_o,
  input wire logic              gate_en_o
);
  stu_timing_type t;
  logic [31:0]    gap_q, gap_d;
  logic           par_q, par_d;
  assign t = tx_timing_o;
  // gap since last tick; parity says whether the next tick is a 15 ms one
  always_comb begin
    gap_d = t.tick_7p5ms ? 32'h1 : gap_q + 32'h1;
    par_d = t.mark ? 1'b1 : (t.tick_7p5ms ? ~par_q : par_q);
  end
  always_ff @(posedge core_clk_i) begin
    gap_q <= rst_i ? 32'h0 : gap_d;
    par_q <= par_d;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  ref_shape_a: assert property ($rose(txref_o) |=> txref_o [*3] ##1 !txref_o [*3] ##1 txref_o)
    else $error("txref shape");
  ref_free_a: assert property (!txref_o [*3] |=> txref_o)
    else $error("txref stopped");
  same_route_a: assert property (rx0_timing_o == t && rx1_timing_o == t)
    else $error("routes differ");
  mark_tick_a: assert property (t.mark |-> t.tick_15ms && t.tick_7p5ms && t.mark_window)
    else $error("mark without ticks");
  pair_tick_a: assert property (t.tick_15ms |-> t.tick_7p5ms)
    else $error("lone 15 ms tick");
  tick_gap_a: assert property (t.tick_7p5ms && !t.mark |-> gap_q == HALF_CYC)
    else $error("tick spacing");
  tick_alt_a: assert property (t.tick_7p5ms && !t.mark |-> t.tick_15ms == !par_q)
    else $error("15 ms tick order");
  win_hold_a: assert property (t.mark |-> t.mark_window [*8])
    else $error("window short");
  gate_need_a: assert property (gate_en_o |-> $past(ref_stable_i))
    else $error("gate without stable");
  bad_read_a: assert property (dsp_req_i.cs && dsp_req_i.rd && dsp_req_i.addr > 4'h2
    |=> dsp_rdata_o == 8'h00)
    else $error("unmapped read");
  cover property (t.mark);
  cover property (t.tick_15ms && !t.mark);
  cover property (gate_en_o);
endmodule
bind stu_timing_unit stu_props #(.HALF_CYC(HALF_CYC)) u_props (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .site_ref_i(site_ref_i),
  .ref_stable_i(ref_stable_i), .loop_align_i(loop_align_i), .dsp_req_i(dsp_req_i),
  .dsp_rdata_o(dsp_rdata_o), .tx_timing_o(tx_timing_o), .rx0_timing_o(rx0_timing_o),
  .rx1_timing_o(rx1_timing_o), .txref_o(txref_o), .gate_en_o(gate_en_o));

/* File: tb/stu_rsp_model.sv */
// receive processor model on the control port
`timescale 1ns/1ps
module stu_rsp_model
  import stu_pkg::*;
(
  // clock
  input  wire logic              core_clk_i,
  // control port
  output stu_dsp_req_type        req_o,
  input  wire logic [DATA_W-1:0] rdata_i
);
  initial req_o = '0;
  // single owner of the port, one access at a time
  task automatic acc(input logic rd, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge core_clk_i) req_o <= '{1'b1, ~rd, rd, a, d};
    @(posedge core_clk_i) req_o <= '0;
    #1 q = rdata_i;
  endtask
endmodule

/* File: tb/stu_timing_unit_bench.sv */
// bench for the station timing unit
`timescale 1ns/1ps
module stu_timing_unit_bench;
  import stu_pkg::*;
  localparam int unsigned HC = 20;
  logic            core_clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            site_ref_i = 1'b0;
  logic            ref_stable_i = 1'b0;
  logic            loop_align_i = 1'b0;
  logic            hold = 1'b0;
  logic [7:0]      q;
  logic [7:0]      rdata;
  logic            txref;
  logic            gate;
  stu_dsp_req_type req;
  stu_timing_type  tx;
  stu_timing_type  rx0;
  stu_timing_type  rx1;
  int              num_errors = 0;
  int              comparisons = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  // carrier held still while hold is up, giving the time mark
  always @(posedge core_clk_i) site_ref_i <= hold ? 1'b0 : ~site_ref_i;
  stu_rsp_model RSP (.core_clk_i(core_clk_i), .req_o(req), .rdata_i(rdata));
  stu_timing_unit #(.HALF_CYC(HC), .GAP_CYC(8)) DUT (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .site_ref_i(site_ref_i),
    .ref_stable_i(ref_stable_i), .loop_align_i(loop_align_i), .dsp_req_i(req),
    .dsp_rdata_o(rdata), .tx_timing_o(tx), .rx0_timing_o(rx0), .rx1_timing_o(rx1),
    .txref_o(txref), .gate_en_o(gate));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic t_regs;
    chk("timing", tx, 0);
    RSP.acc(1'b1, ADDR_WINLEN, 8'h00, q); chk("winlen", q, WINLEN_RESET);
    RSP.acc(1'b1, ADDR_CTRL, 8'h00, q); chk("ctrl", q, CTRL_RESET);
    RSP.acc(1'b1, 4'hf, 8'h00, q); chk("unmapped", q, 0);
    RSP.acc(1'b0, ADDR_WINLEN, 8'h10, q);
    RSP.acc(1'b1, ADDR_WINLEN, 8'h00, q);
    chk("winlen write", q, 8'h10);
    RSP.acc(1'b0, ADDR_WINLEN, WINLEN_RESET, q);
    $display("test regs done");
  endtask
  task automatic t_ref;
    int highs;
    for (int p = 0; p < 2; p++) begin
      highs = 0;
      repeat (TXREF_DIV) begin
        @(posedge core_clk_i); #1;
        highs += (txref === 1'b1);
      end
      chk("txref highs", highs, TXREF_HIGH);
    end
    $display("test ref done");
  endtask
  task automatic t_mark;
    int n;
    RSP.acc(1'b0, ADDR_CTRL, 8'h01, q);
    @(posedge core_clk_i) hold <= 1'b1;
    repeat (12) @(posedge core_clk_i);
    hold <= 1'b0;
    for (n = 0; n < 40 && tx.mark !== 1'b1; n++) @(posedge core_clk_i) #1;
    chk("mark", tx.mark, 1);
    chk("t15 at mark", tx.tick_15ms, 1);
    chk("rx0 route", rx0, tx);
    chk("rx1 route", rx1, tx);
    repeat (HC) @(posedge core_clk_i); #1;
    chk("t75", {tx.tick_7p5ms, tx.tick_15ms}, 2'b10);
    repeat (HC) @(posedge core_clk_i); #1;
    chk("t15", {tx.tick_7p5ms, tx.tick_15ms}, 2'b11);
    repeat (WINLEN_RESET - 2 * HC - 1) @(posedge core_clk_i); #1;
    chk("window last", tx.mark_window, 1);
    @(posedge core_clk_i); #1;
    chk("window end", tx.mark_window, 0);
    $display("test mark done");
  endtask
  task automatic t_gate;
    RSP.acc(1'b0, ADDR_CTRL, 8'h03, q);
    @(posedge core_clk_i) ref_stable_i <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk_i) loop_align_i <= 1'b1;
      @(posedge core_clk_i) loop_align_i <= 1'b0;
      repeat (2) @(posedge core_clk_i); #1;
      chk("gate", gate, i);
    end
    RSP.acc(1'b1, ADDR_STATUS, 8'h00, q);
    chk("status", q & 8'hfe, 8'h1a);
    @(posedge core_clk_i) ref_stable_i <= 1'b0;
    repeat (2) @(posedge core_clk_i); #1;
    chk("gate off", gate, 0);
    $display("test gate done");
  endtask
  initial begin
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1;
    t_regs;
    t_ref;
    t_mark;
    t_gate;
    tally_and_finish;
  end
  initial begin
    #100000;
    num_errors++;
    tally_and_finish;
  end
endmodule
